/* verilog/rdac_pkg.sv */
// rdac_pkg: register map, field positions and reset values for the
// reference dac and comparator control block.
// assumes: a byte-wide register port, two comparators.
package rdac_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int NUM_CMP   = 2;
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 8;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [3:0] REG_DAC_CONTROL   = 4'h0;
   localparam logic [3:0] REG_DAC_LEVEL     = 4'h1;
   localparam logic [3:0] REG_CMP1_FIRST    = 4'h2;
   localparam logic [3:0] REG_CMP1_SECOND   = 4'h3;
   localparam logic [3:0] REG_CMP2_FIRST    = 4'h4;
   localparam logic [3:0] REG_CMP2_SECOND   = 4'h5;
   localparam logic [3:0] REG_CMP_SHARED    = 4'h6;
   localparam logic [3:0] REG_CMP_IRQ_FLAGS = 4'h7;

   // ------------------------------------------------------------------
   // dac control fields and masks
   // ------------------------------------------------------------------
   localparam int DAC_EN_BIT   = 7;
   localparam int DAC_OE_BIT   = 5;
   localparam int DAC_PSS_LSB  = 2;
   localparam logic [7:0] DAC_CONTROL_MASK  = 8'hac; // en, pin oe, source
   localparam logic [7:0] DAC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] DAC_LEVEL_RESET   = 8'h00;
   localparam logic [1:0] PSS_SUPPLY        = 2'h0;
   localparam logic [1:0] PSS_EXT_REF       = 2'h1;
   localparam logic [1:0] PSS_FIXED_REF     = 2'h2;
   localparam logic [1:0] PSS_RESERVED      = 2'h3;

   // ------------------------------------------------------------------
   // comparator first control register fields
   // ------------------------------------------------------------------
   localparam int CMP_EN_BIT   = 7;
   localparam int CMP_OUT_BIT  = 6;
   localparam int CMP_OE_BIT   = 5;
   localparam int CMP_POL_BIT  = 4;
   localparam int CMP_SP_BIT   = 2;
   localparam int CMP_HYS_BIT  = 1;
   localparam int CMP_SYNC_BIT = 0;
   localparam logic [7:0] CMP_FIRST_MASK  = 8'hb7;
   localparam logic [7:0] CMP_FIRST_RESET = 8'h04;

   // ------------------------------------------------------------------
   // comparator second control register fields
   // ------------------------------------------------------------------
   localparam int CMP_RISE_BIT = 7;
   localparam int CMP_FALL_BIT = 6;
   localparam logic [7:0] CMP_SECOND_MASK  = 8'hf7;
   localparam logic [7:0] CMP_SECOND_RESET = 8'h00;

endpackage : rdac_pkg

/* verilog/rdac_ctrl.sv */
// rdac_ctrl: digital control for an 8-bit reference dac and two analog
// comparators, with pin overrides, gate-timer source and edge flags.
// assumes: analog results arrive asynchronously; the gate timer clock
// arrives as a plain input and is sampled on clk.
//
// Operation
// - dac powered only while enable set
// - dac drives its pin when pin enable set
// - dac pin disables digital driver and input
// - dac pin port read returns zero
// - eight-bit level field picks 256 levels
// - source select codes; reserved code unused
// - wake from sleep keeps dac control
// - reset disables dac, clears level
// - comparator works only while enabled
// - result in own and shared register
// - result on pin needs oe, direction, enable
// - pin enable overrides port latch
// - internal result registered each cycle
// - polarity bit inverts comparator output
// - speed select resets to normal speed
// - hysteresis only while its bit set
// - result offered as gate timer source
// - sync latches on timer clock fall
// - sync uses post-prescaler timer clock
// - timer counts on opposite rising edge
// - enabled edges set sticky flag, sw clears
module rdac_ctrl
   import rdac_pkg::*;
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // register port
   input  wire logic [rdac_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [rdac_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_write,
   input  wire logic                      reg_read,
   output logic [rdac_pkg::DATA_W-1:0]    reg_rdata,
   // dac analog controls
   output logic                           ref_dac_power_on,
   output logic [7:0]                     ref_dac_level_out,
   output logic [1:0]                     ref_dac_source_out,
   // dac output pin
   input  wire logic                      ref_dac_pin_port_in,
   output logic                           ref_dac_pin_analog_on,
   output logic                           ref_dac_pin_digital_off,
   output logic                           ref_dac_pin_port_read,
   // comparator analog side
   input  wire logic [rdac_pkg::NUM_CMP-1:0] cmp_raw_result,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_power_on,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_normal_speed,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_hysteresis_on,
   output logic [5:0]                     cmp_input_select_1,
   output logic [5:0]                     cmp_input_select_2,
   // comparator pins
   input  wire logic [rdac_pkg::NUM_CMP-1:0] pin_direction_bit,
   input  wire logic [rdac_pkg::NUM_CMP-1:0] port_data_latch,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_pin_out,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_pin_oe,
   // gate timer and edge flags
   input  wire logic                      gate_timer_clk,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_gate_source,
   output logic [rdac_pkg::NUM_CMP-1:0]   cmp_irq_flag
);
   import rdac_pkg::*;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------

   // write strobes per register
   wire wr_dac_ctl = reg_write && (reg_addr == REG_DAC_CONTROL);
   wire wr_dac_lvl = reg_write && (reg_addr == REG_DAC_LEVEL);
   wire wr_flags   = reg_write && (reg_addr == REG_CMP_IRQ_FLAGS);

   function automatic logic [3:0] first_addr(input int idx);
      first_addr = (idx == 0) ? REG_CMP1_FIRST : REG_CMP2_FIRST;
   endfunction : first_addr

   function automatic logic [3:0] second_addr(input int idx);
      second_addr = (idx == 0) ? REG_CMP1_SECOND : REG_CMP2_SECOND;
   endfunction : second_addr

   // ------------------------------------------------------------------
   // dac registers
   // ------------------------------------------------------------------
   logic [7:0] dac_ctl_q;
   logic [7:0] dac_lvl_q;

   // only implemented bits are stored; no sleep path touches these
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dac_ctl_q <= DAC_CONTROL_RESET;
         dac_lvl_q <= DAC_LEVEL_RESET;
      end else begin
         if (wr_dac_ctl) begin
            dac_ctl_q <= reg_wdata & DAC_CONTROL_MASK;
         end
         if (wr_dac_lvl) begin
            dac_lvl_q <= reg_wdata;
         end
      end
   end

   // dac analog controls
   assign ref_dac_power_on   = dac_ctl_q[DAC_EN_BIT];
   assign ref_dac_level_out  = dac_lvl_q;
   assign ref_dac_source_out = dac_ctl_q[DAC_PSS_LSB +: 2];

   // dac pin: analog path replaces digital driver and input detector
   assign ref_dac_pin_analog_on   = dac_ctl_q[DAC_OE_BIT];
   assign ref_dac_pin_digital_off = dac_ctl_q[DAC_OE_BIT];

   // port read of the dac pin, synchronised before use
   logic dac_pin_s1_q;
   logic dac_pin_s2_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dac_pin_s1_q <= 1'b0;
         dac_pin_s2_q <= 1'b0;
      end else begin
         dac_pin_s1_q <= ref_dac_pin_port_in;
         dac_pin_s2_q <= dac_pin_s1_q;
      end
   end
   assign ref_dac_pin_port_read =
      dac_pin_s2_q & ~dac_ctl_q[DAC_OE_BIT];

   // ------------------------------------------------------------------
   // gate timer clock: synchronised, falling edge detected on clk
   // ------------------------------------------------------------------
   logic gt_s1_q;
   logic gt_s2_q;
   logic gt_s3_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gt_s1_q <= 1'b0;
         gt_s2_q <= 1'b0;
         gt_s3_q <= 1'b0;
      end else begin
         gt_s1_q <= gate_timer_clk;
         gt_s2_q <= gt_s1_q;
         gt_s3_q <= gt_s2_q;
      end
   end
   // the timer counts on rising edges, so latching on falling avoids race
   wire gt_fall = gt_s3_q & ~gt_s2_q;

   // ------------------------------------------------------------------
   // per-comparator logic
   // ------------------------------------------------------------------
   logic [7:0] cmp_first  [NUM_CMP];
   logic [7:0] cmp_second [NUM_CMP];
   logic [NUM_CMP-1:0] result;
   logic [NUM_CMP-1:0] flag;

   genvar g;
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_cmp
         logic [7:0] first_q;
         logic [7:0] second_q;
         logic       raw_s1_q;
         logic       raw_s2_q;
         logic       out_q;
         logic       prev_q;
         logic       sync_q;
         logic       flag_q;
         wire wr_first  = reg_write && (reg_addr == first_addr(g));
         wire wr_second = reg_write && (reg_addr == second_addr(g));
         wire enabled   = first_q[CMP_EN_BIT];
         // disabled comparator reads low before polarity
         wire cmp_raw   = raw_s2_q & enabled;
         wire cmp_d     = cmp_raw ^ first_q[CMP_POL_BIT];
         wire rise      = out_q & ~prev_q;
         wire fall      = ~out_q & prev_q;
         wire hit       = (rise & second_q[CMP_RISE_BIT])
                        | (fall & second_q[CMP_FALL_BIT]);
         wire clr       = wr_flags & reg_wdata[g];

         // control registers
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               first_q  <= CMP_FIRST_RESET;
               second_q <= CMP_SECOND_RESET;
            end else begin
               if (wr_first) begin
                  first_q <= reg_wdata & CMP_FIRST_MASK;
               end
               if (wr_second) begin
                  second_q <= reg_wdata & CMP_SECOND_MASK;
               end
            end
         end

         // analog result synchroniser and per-cycle register
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               raw_s1_q <= 1'b0;
               raw_s2_q <= 1'b0;
               out_q    <= 1'b0;
               prev_q   <= 1'b0;
            end else begin
               raw_s1_q <= cmp_raw_result[g];
               raw_s2_q <= raw_s1_q;
               out_q    <= cmp_d;
               prev_q   <= out_q;
            end
         end

         // timer-synchronised copy and sticky edge flag
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               sync_q <= 1'b0;
               flag_q <= 1'b0;
            end else begin
               if (gt_fall) begin
                  sync_q <= out_q;
               end
               // set wins over a simultaneous clear
               flag_q <= hit | (flag_q & ~clr);
            end
         end

         assign cmp_first[g]  = {first_q[7], out_q, first_q[5:0]};
         assign cmp_second[g] = second_q;
         assign result[g]     = out_q;
         assign flag[g]       = flag_q;

         assign cmp_power_on[g]      = enabled;
         assign cmp_normal_speed[g]  = first_q[CMP_SP_BIT];
         assign cmp_hysteresis_on[g] = first_q[CMP_HYS_BIT];
         // output override ignores enable; pin value needs enable
         assign cmp_pin_oe[g] = first_q[CMP_OE_BIT]
                              & ~pin_direction_bit[g];
         assign cmp_pin_out[g] = first_q[CMP_OE_BIT]
                              ? (cmp_d & enabled)
                              : port_data_latch[g];
         assign cmp_gate_source[g] = first_q[CMP_SYNC_BIT]
                              ? sync_q : out_q;
      end
   endgenerate

   assign cmp_irq_flag       = flag;
   assign cmp_input_select_1 = {cmp_second[0][5:4], 1'b0,
                                cmp_second[0][2:0]};
   assign cmp_input_select_2 = {cmp_second[1][5:4], 1'b0,
                                cmp_second[1][2:0]};

   // ------------------------------------------------------------------
   // read mux, registered: data in the cycle after the strobe
   // ------------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      unique case (reg_addr)
         REG_DAC_CONTROL:   rd_mux = dac_ctl_q;
         REG_DAC_LEVEL:     rd_mux = dac_lvl_q;
         REG_CMP1_FIRST:    rd_mux = cmp_first[0];
         REG_CMP1_SECOND:   rd_mux = cmp_second[0];
         REG_CMP2_FIRST:    rd_mux = cmp_first[1];
         REG_CMP2_SECOND:   rd_mux = cmp_second[1];
         REG_CMP_SHARED:    rd_mux = {6'h00, result};
         REG_CMP_IRQ_FLAGS: rd_mux = {6'h00, flag};
         default:           rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_read ? rd_mux : 8'h00;
      end
   end

endmodule : rdac_ctrl

/* tb/rdac_ctrl_properties.sv */
// rdac_ctrl_properties: port-level checks for the dac/comparator block.
// assumes: bound to every rdac_ctrl instance, single clock domain.
module rdac_ctrl_checker (
   // clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   // dac side
   input wire logic       ref_dac_power_on,
   input wire logic [7:0] ref_dac_level_out,
   input wire logic       ref_dac_pin_analog_on,
   input wire logic       ref_dac_pin_digital_off,
   input wire logic       ref_dac_pin_port_read,
   // comparator side
   input wire logic [1:0] cmp_power_on,
   input wire logic [1:0] cmp_normal_speed,
   input wire logic [1:0] pin_direction_bit,
   input wire logic [1:0] port_data_latch,
   input wire logic [1:0] cmp_pin_out,
   input wire logic [1:0] cmp_pin_oe,
   input wire logic [1:0] cmp_irq_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ---------------------------------------------------------------
   // register writes reach the outputs one cycle later
   // ---------------------------------------------------------------
   a_dac_en_write: assert property (reg_write && reg_addr == 4'h0 |=>
      ref_dac_power_on == $past(reg_wdata[7])) else $error("dac enable");
   a_dac_pin_write: assert property (reg_write && reg_addr == 4'h0 |=>
      ref_dac_pin_analog_on == $past(reg_wdata[5])) else $error("dac pin");
   a_dac_level_write: assert property (reg_write && reg_addr == 4'h1 |=>
      ref_dac_level_out == $past(reg_wdata)) else $error("dac level");
   a_cmp_en_write: assert property (reg_write && reg_addr == 4'h2 |=>
      cmp_power_on[0] == $past(reg_wdata[7])) else $error("cmp enable");

   // ---------------------------------------------------------------
   // pin overrides and reset values
   // ---------------------------------------------------------------
   a_dac_pin_pair: assert property (
      ref_dac_pin_digital_off == ref_dac_pin_analog_on)
      else $error("dac pin digital path not off");
   a_dac_port_zero: assert property (
      ref_dac_pin_analog_on |-> !ref_dac_pin_port_read)
      else $error("dac pin read not zero");
   a_cmp_pin_dir: assert property (
      (cmp_pin_oe & pin_direction_bit) == 2'b00)
      else $error("pin driven while input");
   a_cmp_pin_latch: assert property (
      (~cmp_pin_oe & ~pin_direction_bit & (cmp_pin_out ^ port_data_latch))
      == 2'b00) else $error("pin not from port latch");
   a_speed_reset: assert property (
      $rose(resetn) |-> cmp_normal_speed == 2'b11)
      else $error("speed select not normal after reset");

   // main scenarios reached
   c_dac_pin: cover property (ref_dac_pin_analog_on);
   c_irq_rise: cover property ($rose(cmp_irq_flag[0]));
   c_pin_drive: cover property (cmp_pin_oe[0]);
endmodule : rdac_ctrl_checker

bind rdac_ctrl rdac_ctrl_checker chk_u (.clk, .resetn, .reg_addr,
   .reg_wdata, .reg_write, .ref_dac_power_on, .ref_dac_level_out,
   .ref_dac_pin_analog_on, .ref_dac_pin_digital_off, .ref_dac_pin_port_read,
   .cmp_power_on, .cmp_normal_speed, .pin_direction_bit, .port_data_latch,
   .cmp_pin_out, .cmp_pin_oe, .cmp_irq_flag);

/* tb/rdac_ctrl_tb_top.sv */
// rdac_ctrl_tb_top: directed self-checking bench for rdac_ctrl.
// assumes: rdac_pkg register map, bench drives every port itself.
module rdac_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rdac_pkg::*;

   logic       clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic       ref_dac_pin_port_in = 1'b0, gate_timer_clk = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, ref_dac_level_out;
   logic [1:0] cmp_raw_result = 2'h0, pin_direction_bit = 2'h3;
   logic [1:0] port_data_latch = 2'h0, ref_dac_source_out, cmp_power_on;
   logic [1:0] cmp_normal_speed, cmp_hysteresis_on, cmp_pin_out, cmp_pin_oe;
   logic [1:0] cmp_gate_source, cmp_irq_flag;
   logic [5:0] cmp_input_select_2;
   logic       ref_dac_power_on, ref_dac_pin_analog_on;
   logic       ref_dac_pin_digital_off, ref_dac_pin_port_read;
   int         fails = 0, tests_run = 0, cycles = 0;

   rdac_ctrl dut_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .ref_dac_power_on, .ref_dac_level_out,
      .ref_dac_source_out, .ref_dac_pin_port_in, .ref_dac_pin_analog_on,
      .ref_dac_pin_digital_off, .ref_dac_pin_port_read, .cmp_raw_result,
      .cmp_power_on, .cmp_normal_speed, .cmp_hysteresis_on,
      .cmp_input_select_1(), .cmp_input_select_2, .pin_direction_bit,
      .port_data_latch, .cmp_pin_out, .cmp_pin_oe, .gate_timer_clk,
      .cmp_gate_source, .cmp_irq_flag);

   // 250 MHz clock and hang guard
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         finish_test;
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   task automatic wr(logic [3:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      @(posedge clk);
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 check(what, exp, reg_rdata);
      @(posedge clk);
   endtask : rd

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(REG_DAC_CONTROL, 8'h00, "dac control");
      rd(REG_DAC_LEVEL, 8'h00, "dac level");
      rd(REG_CMP2_FIRST, 8'h04, "cmp2 first");
      rd(4'h9, 8'h00, "unmapped");
      check("dac power", 8'h00, 8'(ref_dac_power_on));
      check("speed", 8'h03, 8'(cmp_normal_speed));
   endtask : t_reset

   task automatic t_dac;
      wr(REG_DAC_CONTROL, 8'hff);
      rd(REG_DAC_CONTROL, 8'hac, "dac control mask");
      check("dac power", 8'h01, 8'(ref_dac_power_on));
      check("dac pin on", 8'h01, 8'(ref_dac_pin_analog_on));
      check("dac pin dig", 8'h01, 8'(ref_dac_pin_digital_off));
      ref_dac_pin_port_in <= 1'b1;
      repeat (4) @(posedge clk);
      check("dac pin read", 8'h00, 8'(ref_dac_pin_port_read));
      for (int s = 0; s < 3; s++) begin
         wr(REG_DAC_CONTROL, 8'(s << DAC_PSS_LSB));
         check("dac source", 8'(s), 8'(ref_dac_source_out));
      end
      check("dac off", 8'h00, 8'(ref_dac_power_on));
      check("dac pin free", 8'h01, 8'(ref_dac_pin_port_read));
      wr(REG_DAC_LEVEL, 8'hff);
      check("dac level", 8'hff, ref_dac_level_out);
   endtask : t_dac

   task automatic t_cmp;
      cmp_raw_result <= 2'b01;
      wr(REG_CMP1_FIRST, 8'h80);
      repeat (4) @(posedge clk);
      rd(REG_CMP1_FIRST, 8'hc0, "cmp1 result");
      rd(REG_CMP_SHARED, 8'h01, "cmp mirror");
      check("cmp power", 8'h01, 8'(cmp_power_on));
      check("cmp speed", 8'h02, 8'(cmp_normal_speed));
      wr(REG_CMP1_FIRST, 8'h90);
      repeat (2) @(posedge clk);
      rd(REG_CMP1_FIRST, 8'h90, "cmp1 inverted");
      wr(REG_CMP1_FIRST, 8'h32);
      port_data_latch <= 2'b11;
      repeat (2) @(posedge clk);
      rd(REG_CMP1_FIRST, 8'h72, "cmp1 disabled");
      check("cmp hyst", 8'h01, 8'(cmp_hysteresis_on));
      check("pin off", 8'h00, 8'(cmp_pin_oe));
      check("pin latch", 8'h02, 8'(cmp_pin_out));
      pin_direction_bit <= 2'b10;
      wr(REG_CMP1_FIRST, 8'ha0);
      repeat (4) @(posedge clk);
      check("pin oe", 8'h01, 8'(cmp_pin_oe));
      check("pin value", 8'h03, 8'(cmp_pin_out));
   endtask : t_cmp

   task automatic t_irq;
      wr(REG_CMP1_SECOND, 8'h80);
      cmp_raw_result <= 2'b00;
      repeat (5) @(posedge clk);
      rd(REG_CMP_IRQ_FLAGS, 8'h00, "no fall flag");
      cmp_raw_result <= 2'b01;
      repeat (5) @(posedge clk);
      rd(REG_CMP_IRQ_FLAGS, 8'h01, "rise flag");
      wr(REG_CMP_IRQ_FLAGS, 8'h01);
      rd(REG_CMP_IRQ_FLAGS, 8'h00, "flag cleared");
      wr(REG_CMP1_SECOND, 8'h40);
      cmp_raw_result <= 2'b00;
      repeat (5) @(posedge clk);
      check("fall flag", 8'h01, 8'(cmp_irq_flag));
      // input selects pass through, bit 3 unimplemented
      wr(REG_CMP2_SECOND, 8'h3d);
      rd(REG_CMP2_SECOND, 8'h35, "cmp2 second");
      check("cmp2 inputs", 8'h35, 8'(cmp_input_select_2));
   endtask : t_irq

   task automatic t_sync;
      wr(REG_CMP1_FIRST, 8'h81);
      gate_timer_clk <= 1'b0;
      repeat (6) @(posedge clk);
      gate_timer_clk <= 1'b1;
      cmp_raw_result <= 2'b01;
      repeat (6) @(posedge clk);
      check("gate held", 8'h00, 8'(cmp_gate_source[0]));
      gate_timer_clk <= 1'b0;
      repeat (6) @(posedge clk);
      check("gate latched", 8'h01, 8'(cmp_gate_source[0]));
      wr(REG_CMP1_FIRST, 8'h80);
      cmp_raw_result <= 2'b00;
      repeat (5) @(posedge clk);
      check("gate direct", 8'h00, 8'(cmp_gate_source[0]));
   endtask : t_sync

   // main sequence, with a reset in mid-run
   initial begin
      do_reset;
      t_reset;
      t_dac;
      do_reset;
      t_reset;
      t_cmp;
      t_irq;
      t_sync;
      finish_test;
   end
endmodule : rdac_ctrl_tb_top
